// [hw/rsf_pkg.sv]
package rsf_pkg;

  // ---------------------------------------------
  // clock and line timing
  // ---------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int BAUD_SLOW = 9600;
  localparam int BAUD_FAST = 115200;
  localparam int BIT_SLOW_CYC = CLK_HZ / BAUD_SLOW;
  localparam int BIT_FAST_CYC = CLK_HZ / BAUD_FAST;
  localparam int GAP_SLOW_US = 1500;
  localparam int GAP_FAST_US = 750;
  localparam int LATENCY_US = 100_000;
  localparam int LATENCY_LONG_US = 200_000;
  localparam int END_BITS = 35;
  localparam int CNT_W = 24;
  localparam int LEN_W = 8;

  // ---------------------------------------------
  // sizes
  // ---------------------------------------------
  localparam int BUF_DEPTH_DEF = 250;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam int MIN_LEN = 4;
  localparam int MAX_READ_REGS_DEF = 120;
  localparam logic [7:0] VENDOR_INIT_FN_DEF = 8'h30;

  // ---------------------------------------------
  // character bit positions
  // ---------------------------------------------
  localparam logic [3:0] BIT_START = 4'h0;
  localparam logic [3:0] BIT_LAST_DATA = 4'h8;
  localparam logic [3:0] BIT_PARITY = 4'h9;
  localparam logic [3:0] CHAR_BITS_MIN = 4'ha;

  // ---------------------------------------------
  // frame fields and codes
  // ---------------------------------------------
  localparam logic [7:0] ADDR_BROADCAST = 8'h00;
  localparam logic [7:0] ADDR_P2P = 8'hfa;
  localparam logic [7:0] ADDR_UNICAST_MAX = 8'hf7;
  localparam logic [7:0] MULTI_REGISTER_READ_FN = 8'h03;
  localparam logic [7:0] SINGLE_REGISTER_WRITE_FN = 8'h06;
  localparam logic [7:0] ECHO_TEST_FN = 8'h08;
  localparam logic [7:0] MULTI_REGISTER_WRITE_FN = 8'h10;
  localparam logic [7:0] FN_EXC_BIT = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_FAILURE = 8'h04;
  localparam logic [7:0] EXC_INIT = 8'h20;
  localparam int IDX_ADDR = 0;
  localparam int IDX_FN = 1;
  localparam int IDX_P0 = 2;
  localparam int IDX_P2 = 4;
  localparam int IDX_P3 = 5;
  localparam logic [LEN_W-1:0] ECHO_LEN = 8'h08;
  localparam logic [1:0] ECHO_LAST = 2'h3;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // ---------------------------------------------
  // types
  // ---------------------------------------------
  typedef logic [CNT_W-1:0] rsf_cnt_type;
  typedef struct packed {
    logic fast;
    logic parity_en;
    logic parity_odd;
    logic two_stop;
  } rsf_cfg_type;
  typedef struct packed {
    logic vendor;
    logic broadcast;
    logic [7:0] fn;
    logic [LEN_W-1:0] len;
  } rsf_req_type;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } rsf_pay_type;
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_CHECK = 2'b01,
    ST_SERVE = 2'b10,
    ST_SEND = 2'b11
  } rsf_state_type;
  typedef enum logic [2:0] {
    PH_ADDR = 3'b000,
    PH_FN = 3'b001,
    PH_BODY = 3'b010,
    PH_CRC_A = 3'b011,
    PH_CRC_B = 3'b100,
    PH_DRAIN = 3'b101
  } rsf_phase_type;

  function automatic logic [15:0] rsf_crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// [hw/rsf_fifo.sv]
`timescale 1ns/100ps
module rsf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = rsf_pkg::FIFO_DEPTH_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  import rsf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

// [hw/rsf_uart_tx.sv]
`timescale 1ns/100ps
module rsf_uart_tx #(
  parameter int BIT_SLOW = rsf_pkg::BIT_SLOW_CYC,
  parameter int BIT_FAST = rsf_pkg::BIT_FAST_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // character format
  input wire rsf_pkg::rsf_cfg_type cfg,
  // byte in
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  // line
  output logic txd,
  output logic busy
);
  import rsf_pkg::*;

  logic [15:0] bit_cyc;
  logic [15:0] cnt;
  logic [3:0] left;
  logic [10:0] sh;
  logic par;

  assign bit_cyc = cfg.fast ? 16'(BIT_FAST) : 16'(BIT_SLOW);
  assign byte_ready = !busy;
  assign par = (^byte_data) ^ cfg.parity_odd;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy <= 1'b0;
      txd <= 1'b1;
      cnt <= 16'h0000;
      left <= 4'h0;
      sh <= '1;
    end else if (!busy) begin
      if (byte_valid) begin
        busy <= 1'b1;
        txd <= 1'b0;
        cnt <= bit_cyc - 16'h0001;
        left <= CHAR_BITS_MIN + {3'h0, cfg.parity_en} + {3'h0, cfg.two_stop};
        sh <= cfg.parity_en ? {2'b11, par, byte_data} : {3'b111, byte_data};
      end
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end else begin
      cnt <= bit_cyc - 16'h0001;
      left <= left - 4'h1;
      sh <= {1'b1, sh[10:1]};
      txd <= sh[0];
      if (left == 4'h1) begin
        busy <= 1'b0;
        txd <= 1'b1;
      end
    end
  end

endmodule

// [hw/rsf_frame_handler.sv]
`timescale 1ns/100ps
module rsf_frame_handler #(
  parameter int BUF_DEPTH = rsf_pkg::BUF_DEPTH_DEF,
  parameter int FIFO_DEPTH = rsf_pkg::FIFO_DEPTH_DEF,
  parameter rsf_pkg::rsf_cnt_type GAP_SLOW_CYC =
    rsf_pkg::rsf_cnt_type'(rsf_pkg::GAP_SLOW_US * rsf_pkg::CLK_MHZ),
  parameter rsf_pkg::rsf_cnt_type GAP_FAST_CYC =
    rsf_pkg::rsf_cnt_type'(rsf_pkg::GAP_FAST_US * rsf_pkg::CLK_MHZ),
  parameter rsf_pkg::rsf_cnt_type LATENCY_CYC =
    rsf_pkg::rsf_cnt_type'(rsf_pkg::LATENCY_US * rsf_pkg::CLK_MHZ),
  parameter rsf_pkg::rsf_cnt_type LATENCY_LONG_CYC =
    rsf_pkg::rsf_cnt_type'(rsf_pkg::LATENCY_LONG_US * rsf_pkg::CLK_MHZ),
  parameter logic [15:0] MAX_READ_REGS = 16'(rsf_pkg::MAX_READ_REGS_DEF),
  parameter logic [7:0] VENDOR_INIT_FN = rsf_pkg::VENDOR_INIT_FN_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // bus line
  input wire logic rxd,
  output logic txd,
  output logic tx_oe,
  // configuration
  input wire rsf_pkg::rsf_cfg_type cfg,
  input wire logic [7:0] device_address,
  input wire logic long_latency,
  // request to application
  output logic req_valid,
  output rsf_pkg::rsf_req_type req,
  input wire logic [7:0] req_index,
  output logic [7:0] req_byte,
  // answer from application
  input wire logic resp_valid,
  input wire logic [7:0] resp_code,
  input wire logic pay_valid,
  input wire rsf_pkg::rsf_pay_type pay,
  output logic pay_ready,
  // status
  output logic init_done,
  output logic frame_dropped
);
  import rsf_pkg::*;

  rsf_state_type state;
  rsf_phase_type phase;
  logic [15:0] bit_cyc;
  logic rx_on;
  logic [15:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_data;
  logic rx_par;
  logic rx_done;
  logic rx_err;
  rsf_cnt_type gap_cnt;
  rsf_cnt_type gap_lim;
  rsf_cnt_type end_lim;
  rsf_cnt_type lat_cnt;
  logic gap_hit;
  logic frame_end;
  logic armed;
  logic in_frame;
  logic frame_bad;
  logic [LEN_W-1:0] len;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [15:0] crc_cur;
  logic [15:0] crc_d1;
  logic [15:0] crc_d2;
  logic [15:0] crc_tx;
  logic [7:0] fn;
  logic [7:0] addr;
  logic vendor;
  logic bcast;
  logic addr_hit;
  logic crc_ok;
  logic accept;
  logic [7:0] next_exc;
  logic [7:0] rsp_exc;
  logic rsp_echo;
  logic [1:0] body_idx;
  logic tx_valid;
  logic tx_ready;
  logic tx_busy;
  logic [7:0] tx_byte;
  logic tx_acc;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_flush;
  rsf_pay_type fifo_out;

  // ---------------------------------------------
  // character receiver
  // ---------------------------------------------
  // baud select
  assign bit_cyc = cfg.fast ? 16'(BIT_FAST_CYC) : 16'(BIT_SLOW_CYC);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rx_on <= 1'b0;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_data <= 8'h00;
      rx_par <= 1'b0;
      rx_done <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_on) begin
        if (!rxd) begin
          rx_on <= 1'b1;
          rx_cnt <= bit_cyc >> 1;
          rx_bit <= BIT_START;
          rx_par <= cfg.parity_odd;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= bit_cyc - 16'h0001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == BIT_START) begin
          if (rxd) begin
            rx_on <= 1'b0;
          end
        end else if (rx_bit <= BIT_LAST_DATA) begin
          rx_data <= {rxd, rx_data[7:1]};
          rx_par <= rx_par ^ rxd;
        end else if (rx_bit == BIT_PARITY && cfg.parity_en) begin
          rx_par <= rx_par ^ rxd;
        end else begin
          rx_on <= 1'b0;
          rx_done <= 1'b1;
          rx_err <= !rxd || (cfg.parity_en && rx_par);
        end
      end
    end
  end

  // ---------------------------------------------
  // silence timing
  // ---------------------------------------------
  assign gap_lim = cfg.fast ? GAP_FAST_CYC : GAP_SLOW_CYC;
  assign end_lim = gap_lim + CNT_W'(END_BITS * bit_cyc);
  assign frame_end = gap_cnt == end_lim;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gap_cnt <= '0;
      gap_hit <= 1'b0;
    end else begin
      if (rx_on) begin
        gap_cnt <= '0;
      end else if (gap_cnt != '1) begin
        gap_cnt <= gap_cnt + 1'b1;
      end
      if (!rx_on && !rxd) begin
        gap_hit <= gap_cnt > gap_lim;
      end
    end
  end

  // ---------------------------------------------
  // frame collection
  // ---------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      armed <= 1'b0;
      in_frame <= 1'b0;
      frame_bad <= 1'b0;
      len <= '0;
      crc_cur <= CRC_INIT;
      crc_d1 <= CRC_INIT;
      crc_d2 <= CRC_INIT;
    end else if (state == ST_RX) begin
      if (frame_end) begin
        armed <= 1'b1;
        in_frame <= 1'b0;
      end else if (rx_done && armed) begin
        if (!in_frame) begin
          in_frame <= 1'b1;
          frame_bad <= rx_err;
          len <= 8'h01;
          crc_cur <= rsf_crc_step(CRC_INIT, rx_data);
          crc_d1 <= CRC_INIT;
          crc_d2 <= CRC_INIT;
        end else if (gap_hit || rx_err || len == LEN_W'(BUF_DEPTH)) begin
          frame_bad <= 1'b1;
        end else begin
          len <= len + 8'h01;
          crc_cur <= rsf_crc_step(crc_cur, rx_data);
          crc_d1 <= crc_cur;
          crc_d2 <= crc_d1;
        end
      end
    end else begin
      in_frame <= 1'b0;
      armed <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (state == ST_RX && rx_done && armed && !frame_end) begin
      if (!in_frame) begin
        buf_mem[IDX_ADDR] <= rx_data;
      end else if (len != LEN_W'(BUF_DEPTH)) begin
        buf_mem[len] <= rx_data;
      end
    end
  end

  // ---------------------------------------------
  // frame evaluation
  // ---------------------------------------------
  assign addr = buf_mem[IDX_ADDR];
  assign fn = buf_mem[IDX_FN];
  assign vendor = !(fn == MULTI_REGISTER_READ_FN || fn == SINGLE_REGISTER_WRITE_FN ||
                    fn == ECHO_TEST_FN || fn == MULTI_REGISTER_WRITE_FN);
  assign bcast = addr == ADDR_BROADCAST;
  assign addr_hit = bcast || addr == ADDR_P2P ||
    (addr == device_address && device_address != ADDR_BROADCAST &&
     device_address <= ADDR_UNICAST_MAX);
  assign crc_ok = vendor ?
    crc_d2 == {buf_mem[len - 8'h02], buf_mem[len - 8'h01]} :
    crc_d2 == {buf_mem[len - 8'h01], buf_mem[len - 8'h02]};
  assign accept = !frame_bad && len >= LEN_W'(MIN_LEN) && crc_ok && addr_hit;

  always_comb begin
    next_exc = EXC_NONE;
    if (fn[7]) begin
      next_exc = EXC_FUNCTION;
    end else if (vendor && !init_done && fn != VENDOR_INIT_FN) begin
      next_exc = EXC_INIT;
    end else if (fn == ECHO_TEST_FN) begin
      if (len != ECHO_LEN) begin
        next_exc = EXC_VALUE;
      end else if (buf_mem[IDX_P0] != 8'h00 || buf_mem[IDX_P0 + 1] != 8'h00) begin
        next_exc = EXC_FUNCTION;
      end
    end else if (fn == MULTI_REGISTER_READ_FN) begin
      if ({buf_mem[IDX_P2], buf_mem[IDX_P3]} == 16'h0000 ||
          {buf_mem[IDX_P2], buf_mem[IDX_P3]} > MAX_READ_REGS) begin
        next_exc = EXC_VALUE;
      end
    end
  end

  // ---------------------------------------------
  // control sequence
  // ---------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= ST_RX;
      rsp_exc <= EXC_NONE;
      rsp_echo <= 1'b0;
      init_done <= 1'b0;
      frame_dropped <= 1'b0;
      lat_cnt <= '0;
    end else begin
      frame_dropped <= 1'b0;
      unique case (state)
        ST_RX: begin
          if (frame_end && in_frame && armed) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          lat_cnt <= '0;
          rsp_exc <= next_exc;
          rsp_echo <= fn == ECHO_TEST_FN;
          if (!accept) begin
            frame_dropped <= 1'b1;
            state <= ST_RX;
          end else if (next_exc != EXC_NONE || fn == ECHO_TEST_FN) begin
            state <= bcast ? ST_RX : ST_SEND;
          end else begin
            state <= ST_SERVE;
          end
        end
        ST_SERVE: begin
          lat_cnt <= lat_cnt + 1'b1;
          if (resp_valid) begin
            if (vendor && fn == VENDOR_INIT_FN && resp_code == EXC_NONE) begin
              init_done <= 1'b1;
            end
            rsp_exc <= resp_code;
            state <= bcast ? ST_RX : ST_SEND;
          end else if (lat_cnt == (long_latency ? LATENCY_LONG_CYC : LATENCY_CYC)) begin
            state <= ST_RX;
          end
        end
        ST_SEND: begin
          if (phase == PH_DRAIN && !tx_busy) begin
            state <= ST_RX;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------
  // application side
  // ---------------------------------------------
  assign req_valid = state == ST_SERVE;
  assign req = '{vendor: vendor, broadcast: bcast, fn: fn, len: len};
  assign fifo_flush = state == ST_RX;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      req_byte <= 8'h00;
    end else begin
      req_byte <= buf_mem[req_index];
    end
  end

  // ---------------------------------------------
  // reply assembly
  // ---------------------------------------------
  // driver only while replying
  assign tx_oe = state == ST_SEND;
  assign tx_acc = tx_valid && tx_ready;
  assign fifo_pop = tx_oe && phase == PH_BODY && rsp_exc == EXC_NONE && !rsp_echo && tx_ready;

  always_comb begin
    tx_valid = tx_oe;
    tx_byte = 8'h00;
    case (phase)
      PH_ADDR: tx_byte = addr;
      PH_FN: tx_byte = fn | (rsp_exc != EXC_NONE ? FN_EXC_BIT : 8'h00);
      PH_BODY: begin
        if (rsp_exc != EXC_NONE) begin
          tx_byte = rsp_exc;
        end else if (rsp_echo) begin
          tx_byte = buf_mem[IDX_P0 + int'(body_idx)];
        end else begin
          tx_byte = fifo_out.data;
          tx_valid = tx_oe && fifo_valid;
        end
      end
      PH_CRC_A: tx_byte = vendor ? crc_tx[15:8] : crc_tx[7:0];
      PH_CRC_B: tx_byte = vendor ? crc_tx[7:0] : crc_tx[15:8];
      default: tx_valid = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn || !tx_oe) begin
      phase <= PH_ADDR;
      body_idx <= 2'h0;
      crc_tx <= CRC_INIT;
    end else if (tx_acc) begin
      if (phase <= PH_BODY) begin
        crc_tx <= rsf_crc_step(crc_tx, tx_byte);
      end
      case (phase)
        PH_ADDR: phase <= PH_FN;
        PH_FN: phase <= PH_BODY;
        PH_BODY: begin
          body_idx <= body_idx + 2'h1;
          if (rsp_exc != EXC_NONE || (rsp_echo && body_idx == ECHO_LAST) ||
              (!rsp_echo && fifo_out.last)) begin
            phase <= PH_CRC_A;
          end
        end
        PH_CRC_A: phase <= PH_CRC_B;
        PH_CRC_B: phase <= PH_DRAIN;
        default: phase <= PH_DRAIN;
      endcase
    end
  end

  // ---------------------------------------------
  // payload buffer and transmitter
  // ---------------------------------------------
  rsf_fifo #(
    .WIDTH($bits(rsf_pay_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .flush(fifo_flush),
    .in_valid(pay_valid),
    .in_data(pay),
    .in_ready(pay_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_out),
    .out_ready(fifo_pop)
  );

  rsf_uart_tx #(
    .BIT_SLOW(BIT_SLOW_CYC),
    .BIT_FAST(BIT_FAST_CYC)
  ) u_tx (
    .mclk(mclk),
    .resetn(resetn),
    .cfg(cfg),
    .byte_valid(tx_valid),
    .byte_data(tx_byte),
    .byte_ready(tx_ready),
    .txd(txd),
    .busy(tx_busy)
  );

endmodule

// [tb/rsf_chk.sv]
`timescale 1ns/100ps
module rsf_chk (
  // watched ports
  input wire logic mclk,
  input wire logic resetn,
  input wire logic txd,
  input wire logic tx_oe,
  input wire logic req_valid,
  input wire rsf_pkg::rsf_req_type req,
  input wire logic resp_valid,
  input wire logic init_done,
  input wire logic frame_dropped
);
  localparam int LAT_MAX = 1000;
  logic [10:0] serve_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // cycles spent waiting for the application
  always_ff @(posedge mclk) begin
    if (!resetn || !req_valid) begin
      serve_cnt <= 11'h000;
    end else begin
      serve_cnt <= serve_cnt + 11'h001;
    end
  end
  sequence start_bit_s;
    !txd [*8];
  endsequence
  sequence quiet_s;
    !tx_oe [*8];
  endsequence
  line_idle_a: assert property (!tx_oe |-> txd)
    else $error("line not idle");
  start_bit_a: assert property ($rose(tx_oe) |=> start_bit_s)
    else $error("no start bit");
  serve_quiet_a: assert property (req_valid |-> !tx_oe)
    else $error("sent while serving");
  drop_quiet_a: assert property (frame_dropped |-> quiet_s)
    else $error("reply after drop");
  drop_pulse_a: assert property (frame_dropped |=> !frame_dropped)
    else $error("drop pulse long");
  init_hold_a: assert property (init_done |=> init_done)
    else $error("init lost");
  answer_taken_a: assert property (req_valid && resp_valid |=> !req_valid)
    else $error("request kept");
  latency_bound_a: assert property (req_valid |-> serve_cnt <= 11'(LAT_MAX))
    else $error("latency exceeded");
  release_a: assert property ($fell(tx_oe) |-> txd && $past(txd))
    else $error("early release");
  broadcast_quiet_a: assert property (req_valid && req.broadcast && resp_valid |=> quiet_s)
    else $error("broadcast answered");
endmodule
bind rsf_frame_handler rsf_chk rsf_chk_i (.mclk(mclk), .resetn(resetn), .txd(txd),
  .tx_oe(tx_oe), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
  .init_done(init_done), .frame_dropped(frame_dropped));

// [tb/rsf_master.sv]
`timescale 1ns/100ps
module rsf_master #(
  parameter int BIT = 173
) (
  // clock and format
  input wire logic mclk,
  input wire logic par_odd,
  // bus line
  output logic rxd,
  input wire logic txd
);
  logic [7:0] got_q[$];
  logic [7:0] d;
  logic [10:0] c;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      c = {1'b1, ^f[i] ^ par_odd, f[i], 1'b0};
      for (int b = 0; b < 11; b++) begin
        rxd <= c[b];
        repeat (BIT) @(posedge mclk);
      end
    end
  endtask
  always begin
    @(negedge txd);
    repeat (BIT + BIT / 2) @(posedge mclk);
    for (int b = 0; b < 8; b++) begin
      d[b] = txd;
      repeat (BIT) @(posedge mclk);
    end
    got_q.push_back(d);
    repeat (BIT) @(posedge mclk);
  end
endmodule

// [tb/rsf_frame_handler_tb_top.sv]
`timescale 1ns/100ps
module rsf_frame_handler_tb_top;
  import rsf_pkg::*;
  typedef logic [7:0] rsf_bytes_type[$];
  localparam int ARM = 350 + 35 * BIT_FAST_CYC;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic rxd, txd, tx_oe, req_valid, long_latency, init_done, frame_dropped;
  logic resp_valid = 1'b0;
  logic pay_valid = 1'b0;
  logic pay_ready;
  rsf_pay_type pay = '0;
  logic [7:0] req_index = 8'h00;
  logic [7:0] resp_code = 8'h00;
  logic [7:0] device_address, req_byte, dh, dl;
  rsf_cfg_type cfg;
  rsf_req_type req;
  rsf_bytes_type q;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h6c754ecd;
  always #25 mclk = ~mclk;
  rsf_frame_handler #(.GAP_SLOW_CYC(24'h258), .GAP_FAST_CYC(24'h12c),
    .LATENCY_CYC(24'h1f4), .LATENCY_LONG_CYC(24'h3e8)) rsf_frame_handler_i (
    .mclk(mclk), .resetn(resetn), .rxd(rxd), .txd(txd), .tx_oe(tx_oe), .cfg(cfg),
    .device_address(device_address), .long_latency(long_latency), .req_valid(req_valid),
    .req(req), .req_index(req_index), .req_byte(req_byte), .resp_valid(resp_valid),
    .resp_code(resp_code), .pay_valid(pay_valid), .pay(pay), .pay_ready(pay_ready),
    .init_done(init_done), .frame_dropped(frame_dropped));
  rsf_master #(.BIT(BIT_FAST_CYC)) rsf_master_i (.mclk(mclk),
    .par_odd(cfg.parity_odd), .rxd(rxd), .txd(txd));
  function automatic rsf_bytes_type frame(rsf_bytes_type b, logic hi);
    logic [15:0] c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    b.push_back(hi ? c[15:8] : c[7:0]);
    b.push_back(hi ? c[7:0] : c[15:8]);
    return b;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_for(ref logic s, input logic lvl, input int n);
    int k = 0;
    while (s !== lvl) begin
      @(posedge mclk);
      k++;
      if (k > n) begin
        num_errors++;
        tally_and_finish();
      end
    end
  endtask
  task automatic quiet(string what);
    repeat (3000) @(posedge mclk);
    chk(what, 16'h0, 16'(rsf_master_i.got_q.size()));
    $display("test %s done", what);
  endtask
  task automatic reply(string what, rsf_bytes_type e);
    wait_for(tx_oe, 1'b1, 30000);
    wait_for(tx_oe, 1'b0, 30000);
    repeat (BIT_FAST_CYC) @(posedge mclk);
    chk(what, 16'(e.size()), 16'(rsf_master_i.got_q.size()));
    foreach (e[i]) chk(what, 16'(e[i]), 16'(rsf_master_i.got_q[i]));
    rsf_master_i.got_q.delete();
    $display("test %s done", what);
  endtask
  task automatic answer(input logic [7:0] code, input rsf_bytes_type p);
    wait_for(req_valid, 1'b1, 8000);
    chk("pay ready", 16'h1, 16'(pay_ready));
    foreach (p[i]) begin
      pay_valid <= 1'b1;
      pay <= '{last: i == p.size() - 1, data: p[i]};
      @(posedge mclk);
    end
    pay_valid <= 1'b0;
    resp_code <= code;
    resp_valid <= 1'b1;
    @(posedge mclk);
    resp_valid <= 1'b0;
  endtask
  task automatic drop(string what, rsf_bytes_type f);
    rsf_master_i.send(f);
    wait_for(frame_dropped, 1'b1, 8000);
    quiet(what);
  endtask
  initial begin
    device_address = 8'(1 + {$random(seed)} % 247);
    cfg = {1'b1, 1'b1, 1'($random(seed)), 1'b0};
    long_latency = 1'($random(seed));
    dh = 8'($random(seed));
    dl = 8'($random(seed));
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (ARM) @(posedge mclk);
    q = frame('{device_address, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
    q[7] = ~q[7];
    drop("bad check", q);
    drop("reserved", frame('{8'hfb, 8'h03}, 1'b0));
    rsf_master_i.send(frame('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0));
    wait_for(req_valid, 1'b1, 8000);
    chk("broadcast", 16'h1, 16'(req.broadcast));
    chk("vendor", 16'h0, 16'(req.vendor));
    chk("fn", 16'h3, 16'(req.fn));
    chk("len", 16'h8, 16'(req.len));
    req_index <= 8'h01;
    repeat (2) @(posedge mclk);
    chk("req byte", 16'h3, 16'(req_byte));
    resp_valid <= 1'b1;
    @(posedge mclk);
    resp_valid <= 1'b0;
    quiet("broadcast quiet");
    rsf_master_i.send(frame('{device_address, 8'h31}, 1'b1));
    reply("init exc", frame('{device_address, 8'hb1, 8'h20}, 1'b1));
    chk("init", 16'h0, 16'(init_done));
    repeat (10000) @(posedge mclk);
    q = frame('{8'hfa, 8'h08, 8'h00, 8'h00, dh, dl}, 1'b0);
    rsf_master_i.send(q);
    reply("echo", q);
    repeat (10000) @(posedge mclk);
    rsf_master_i.send(frame('{device_address, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0));
    answer(8'h00, '{8'h02, dh, dl});
    reply("register read", frame('{device_address, 8'h03, 8'h02, dh, dl}, 1'b0));
    tally_and_finish();
  end
endmodule
